// [cia_pkg.sv]
// Constants and types shared by the interrupt and addressing unit
`default_nettype none

package cia_pkg;

  // ==========================================================
  // Widths
  localparam int PC_W = 10;
  localparam int ADDR_W = 12;
  localparam int SP_W = 4;
  localparam int NUM_SRC = 4;
  localparam int SEL_W = 2;

  // ==========================================================
  // Source indices, 0 is the most urgent
  localparam int SRC_WAKE = 0;
  localparam int SRC_WDOG = 1;
  localparam int SRC_PWM = 2;
  localparam int SRC_TRAP = 3;

  // ==========================================================
  // Stack and reset values
  localparam logic [7:0] STACK_PAGE = 8'h03;
  localparam logic [SP_W-1:0] SP_RESET = 4'hF;
  localparam logic [SP_W-1:0] SP_ONE = 4'h1;
  localparam logic [SP_W-1:0] SP_STEP = 4'h2;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;

  // ==========================================================
  // Memory spaces and vectors
  localparam logic [ADDR_W-1:0] PROG_BASE = 12'hC00;
  localparam logic [ADDR_W-1:0] VEC_WAKE = 12'hFFA;
  localparam logic [ADDR_W-1:0] VEC_WDOG = 12'hFF6;
  localparam logic [ADDR_W-1:0] VEC_PWM = 12'hFF8;
  localparam logic [ADDR_W-1:0] VEC_TRAP = 12'hFFC;
  localparam int IDX_SPACE_BIT = 10;

  // ==========================================================
  // Timing and operand encodings
  localparam int ENTRY_CYCLES = 5;
  localparam logic [5:0] REL_BIAS = 6'h1F;

  typedef enum logic [3:0] {
    ST_IDLE, ST_E1, ST_E2, ST_E3, ST_E4, ST_E5, ST_R1, ST_R2, ST_R3
  } cia_state_type;

  typedef enum logic [2:0] {
    MODE_INH, MODE_IMM, MODE_DIR, MODE_IDX, MODE_ABS, MODE_REL
  } cia_mode_type;

endpackage

`default_nettype wire

// [cia_arb.sv]
// Fixed priority selection of the pending interrupt source
`default_nettype none

module cia_arb (
  input wire logic [cia_pkg::NUM_SRC-1:0] pend, // Pending sources
  input wire logic mask,                        // Global mask bit
  output logic take,                            // Some source eligible
  output logic [cia_pkg::SEL_W-1:0] sel,        // Winning source
  output logic [cia_pkg::ADDR_W-1:0] vec        // Its vector address
);
  import cia_pkg::*;

  logic [NUM_SRC-1:0] elig;

  always_comb begin
    elig = pend;
    // Maskable sources need the global mask, the trap does not
    elig[SRC_WAKE] = pend[SRC_WAKE] & mask;
    elig[SRC_WDOG] = pend[SRC_WDOG] & mask;
    elig[SRC_PWM] = pend[SRC_PWM] & mask;
    take = |elig;
    sel = '0;
    // Scan from least to most urgent so the lowest index wins
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (elig[i]) begin
        sel = SEL_W'(i);
      end
    end
    case (sel)
      SEL_W'(SRC_WAKE): vec = VEC_WAKE;
      SEL_W'(SRC_WDOG): vec = VEC_WDOG;
      SEL_W'(SRC_PWM): vec = VEC_PWM;
      default: vec = VEC_TRAP;
    endcase
  end

endmodule // cia_arb

`default_nettype wire

// [cia_addr.sv]
// Operand address generation for all addressing modes
`default_nettype none

module cia_addr (
  input wire cia_pkg::cia_mode_type mode,    // Addressing mode
  input wire logic [10:0] x_ptr,             // Index pointer
  input wire logic [7:0] op_a,               // First operand byte
  input wire logic [7:0] op_b,               // Second operand byte
  input wire logic [cia_pkg::PC_W-1:0] pc,   // Current program counter
  output logic [cia_pkg::ADDR_W-1:0] ea,     // Effective address
  output logic [7:0] imm,                    // Immediate operand
  output logic [cia_pkg::PC_W-1:0] jump,     // Jump target
  output logic [1:0] nbytes                  // Operand bytes used
);
  import cia_pkg::*;

  logic [PC_W-1:0] idx_sum;

  always_comb begin
    idx_sum = PC_W'(x_ptr[PC_W-1:0] + {2'h0, op_a});
    ea = '0;
    imm = 8'h00;
    jump = pc;
    nbytes = 2'h0;
    case (mode)
      MODE_IDX: begin
        nbytes = 2'h1;
        // Top pointer bit picks program space, else data space
        if (x_ptr[IDX_SPACE_BIT]) begin
          ea = PROG_BASE | {2'h0, idx_sum};
        end else begin
          ea = {2'h0, idx_sum};
        end
      end
      MODE_DIR: begin
        nbytes = 2'h1;
        ea = {4'h0, op_a};
      end
      MODE_IMM: begin
        nbytes = 2'h1;
        imm = op_a;
      end
      MODE_ABS: begin
        nbytes = 2'h2;
        jump = {op_a[1:0], op_b};
        ea = PROG_BASE | {2'h0, op_a[1:0], op_b};
      end
      MODE_REL: begin
        nbytes = 2'h1;
        // Field 0..63 maps onto displacement -31..+32
        jump = PC_W'(pc + {4'h0, op_a[5:0]} - {4'h0, REL_BIAS});
      end
      default: begin
        nbytes = 2'h0;
      end
    endcase
  end

endmodule // cia_addr

`default_nettype wire

// [cia_core.sv]
// Interrupt entry, return, mask and operand addressing of the core
`default_nettype none

// Behaviour
// - Sign flag copies bit 7 of each arithmetic or logic result.
// - With mask clear, maskable requests stay pending and are not taken.
// - With mask set, a pending maskable request is recognised.
// - Reset clears the mask; only a software instruction sets it.
// - Entry clears the mask after stacking and vector fetch.
// - Entry waits for instruction end, stacks PC, jumps to source vector.
// - Entry from stacking to vector start takes exactly five cycles.
// - Interrupt return pops in reverse order, sets mask, resumes there.
// - Four sources; three masked, the software trap never masked.
// - Software trap always enters, stacking PC and clearing the mask.
// - Simultaneous requests: wake-up, watchdog, PWM timer, trap.
// - Indexed address is 8-bit offset plus low ten pointer bits.
// - Direct mode uses its 8-bit field as data address.
// - Immediate mode carries its 8-bit operand value.
// - Inherent mode uses no operand bytes.
// - Absolute mode builds a 10-bit program address from two bytes.
// - Short relative jump adds a displacement of -31 to +32.
// - Push lowers stack pointer by two, pull raises it by two.
// - Top index pointer bit selects data or program space.
module cia_core (
  input wire logic clk,                         // Instruction clock
  input wire logic reset_n,                     // Synchronous reset
  input wire logic instr_done,                  // Current instr ends
  input wire logic exec_trap,                   // Software trap executed
  input wire logic exec_interrupt_return_instruction,                   // Interrupt return
  input wire logic exec_ret,                    // Subroutine return
  input wire logic exec_mask_set,               // Instr sets mask
  input wire logic exec_mask_clr,               // Instr clears mask
  input wire logic sp_load,                     // Instr loads SP
  input wire logic [cia_pkg::SP_W-1:0] sp_wdata, // New SP value
  input wire logic [cia_pkg::PC_W-1:0] pc_in,   // Return address
  input wire logic wake_edge_request,           // Wake-up edge event
  input wire logic watchdog_timer_request,      // Watchdog timer event
  input wire logic pwm_timer_request,           // PWM timer event
  input wire logic [7:0] mem_rdata,             // Read data, 1 cycle
  input wire logic result_valid,                // ALU result strobe
  input wire logic [7:0] result,                // ALU result
  input wire cia_pkg::cia_mode_type addr_mode,  // Operand mode
  input wire logic [10:0] x_ptr,                // Index pointer
  input wire logic [7:0] op_a,                  // Operand byte one
  input wire logic [7:0] op_b,                  // Operand byte two
  output logic busy,                            // Sequence running
  output logic mem_we,                          // Stack write
  output logic mem_re,                          // Memory read
  output logic [cia_pkg::ADDR_W-1:0] mem_addr,  // Memory address
  output logic [7:0] mem_wdata,                 // Write data
  output logic pc_load,                         // Load PC pulse
  output logic [cia_pkg::PC_W-1:0] pc_target,   // New PC value
  output logic [cia_pkg::SP_W-1:0] stack_ptr,   // Stack pointer
  output logic global_mask,                     // Global mask bit
  output logic sign_flag,                       // Sign flag
  output logic [cia_pkg::NUM_SRC-1:0] pending,  // Pending sources
  output logic [cia_pkg::ADDR_W-1:0] operand_ea, // Effective address
  output logic [7:0] operand_imm,               // Immediate value
  output logic [cia_pkg::PC_W-1:0] jump_target, // Jump destination
  output logic [1:0] operand_bytes              // Operand byte count
);
  import cia_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    cia_state_type st;
    logic [NUM_SRC-1:0] pend;
    logic [ADDR_W-1:0] vec;
    logic [7:0] lo;
    logic is_interrupt_return_instruction;
    logic mask;
    logic [SP_W-1:0] sp;
    logic busy;
    logic mem_we;
    logic mem_re;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0] mem_wdata;
    logic pc_load;
    logic [PC_W-1:0] pc_target;
    logic sign;
    logic [ADDR_W-1:0] ea;
    logic [7:0] imm;
    logic [PC_W-1:0] jump;
    logic [1:0] nbytes;
  } cia_core_type;

  cia_core_type state_r;
  cia_core_type state_nxt;
  logic arb_take;
  logic [SEL_W-1:0] arb_sel;
  logic [ADDR_W-1:0] arb_vec;
  logic [ADDR_W-1:0] a_ea;
  logic [7:0] a_imm;
  logic [PC_W-1:0] a_jump;
  logic [1:0] a_nbytes;
  logic [NUM_SRC-1:0] clr;
  logic [NUM_SRC-1:0] req;

  function automatic logic [ADDR_W-1:0] stack_at(
    input logic [SP_W-1:0] sp
  );
    return {STACK_PAGE, sp};
  endfunction

  // ==========================================================
  // Sub blocks
  cia_arb u_arb (
    .pend(state_r.pend),
    .mask(state_r.mask),
    .take(arb_take),
    .sel(arb_sel),
    .vec(arb_vec)
  );

  cia_addr u_addr (
    .mode(addr_mode),
    .x_ptr(x_ptr),
    .op_a(op_a),
    .op_b(op_b),
    .pc(pc_in),
    .ea(a_ea),
    .imm(a_imm),
    .jump(a_jump),
    .nbytes(a_nbytes)
  );

  // ==========================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.mem_we = 1'b0;
    state_nxt.mem_re = 1'b0;
    state_nxt.pc_load = 1'b0;
    clr = '0;
    req = '0;
    req[SRC_WAKE] = wake_edge_request;
    req[SRC_WDOG] = watchdog_timer_request;
    req[SRC_PWM] = pwm_timer_request;
    req[SRC_TRAP] = exec_trap;
    if (result_valid) begin
      state_nxt.sign = result[7];
    end
    state_nxt.ea = a_ea;
    state_nxt.imm = a_imm;
    state_nxt.jump = a_jump;
    state_nxt.nbytes = a_nbytes;
    case (state_r.st)
      ST_IDLE: begin
        if (sp_load) begin
          state_nxt.sp = sp_wdata;
        end
        if (exec_mask_set) begin
          state_nxt.mask = 1'b1;
        end else if (exec_mask_clr) begin
          state_nxt.mask = 1'b0;
        end
        if (exec_interrupt_return_instruction || exec_ret) begin
          state_nxt.is_interrupt_return_instruction = exec_interrupt_return_instruction;
          state_nxt.st = ST_R1;
          state_nxt.busy = 1'b1;
          state_nxt.mem_re = 1'b1;
          state_nxt.mem_addr = stack_at(SP_W'(state_r.sp + SP_ONE));
        end else if (instr_done && arb_take) begin
          clr[arb_sel] = 1'b1;
          state_nxt.vec = arb_vec;
          state_nxt.st = ST_E1;
          state_nxt.busy = 1'b1;
          state_nxt.mem_we = 1'b1;
          state_nxt.mem_addr = stack_at(state_r.sp);
          state_nxt.mem_wdata = pc_in[7:0];
          state_nxt.lo = {6'h00, pc_in[9:8]};
        end
      end
      ST_E1: begin
        state_nxt.st = ST_E2;
        state_nxt.mem_we = 1'b1;
        state_nxt.mem_addr = stack_at(SP_W'(state_r.sp - SP_ONE));
        state_nxt.mem_wdata = state_r.lo;
        state_nxt.sp = SP_W'(state_r.sp - SP_STEP);
      end
      ST_E2: begin
        state_nxt.st = ST_E3;
        state_nxt.mem_re = 1'b1;
        state_nxt.mem_addr = state_r.vec;
      end
      ST_E3: begin
        state_nxt.st = ST_E4;
        state_nxt.mem_re = 1'b1;
        state_nxt.mem_addr = ADDR_W'(state_r.vec + 12'h001);
      end
      ST_E4: begin
        state_nxt.st = ST_E5;
        state_nxt.lo = mem_rdata;
      end
      ST_E5: begin
        // Fifth cycle: vector complete, now the mask may drop
        state_nxt.st = ST_IDLE;
        state_nxt.busy = 1'b0;
        state_nxt.pc_load = 1'b1;
        state_nxt.pc_target = {mem_rdata[1:0], state_r.lo};
        state_nxt.mask = 1'b0;
      end
      ST_R1: begin
        state_nxt.st = ST_R2;
        state_nxt.mem_re = 1'b1;
        state_nxt.mem_addr = stack_at(SP_W'(state_r.sp + SP_STEP));
      end
      ST_R2: begin
        state_nxt.st = ST_R3;
        state_nxt.lo = mem_rdata;
      end
      ST_R3: begin
        state_nxt.st = ST_IDLE;
        state_nxt.busy = 1'b0;
        state_nxt.pc_load = 1'b1;
        state_nxt.pc_target = {state_r.lo[1:0], mem_rdata};
        state_nxt.sp = SP_W'(state_r.sp + SP_STEP);
        if (state_r.is_interrupt_return_instruction) begin
          state_nxt.mask = 1'b1;
        end
      end
      default: begin
        state_nxt.st = ST_IDLE;
        state_nxt.busy = 1'b0;
      end
    endcase
    // A new request beats the clear of its own flag
    state_nxt.pend = (state_r.pend & ~clr) | req;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= '0;
      state_r.st <= ST_IDLE;
      state_r.mask <= 1'b0;
      state_r.sp <= SP_RESET;
      state_r.pc_target <= PC_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign busy = state_r.busy;
  assign mem_we = state_r.mem_we;
  assign mem_re = state_r.mem_re;
  assign mem_addr = state_r.mem_addr;
  assign mem_wdata = state_r.mem_wdata;
  assign pc_load = state_r.pc_load;
  assign pc_target = state_r.pc_target;
  assign stack_ptr = state_r.sp;
  assign global_mask = state_r.mask;
  assign sign_flag = state_r.sign;
  assign pending = state_r.pend;
  assign operand_ea = state_r.ea;
  assign operand_imm = state_r.imm;
  assign jump_target = state_r.jump;
  assign operand_bytes = state_r.nbytes;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic idle_done;
  logic no_ret;
  assign idle_done = (state_r.st == ST_IDLE) && instr_done;
  assign no_ret = !exec_interrupt_return_instruction && !exec_ret;

  a_sign_follows_msb: assert property (
    result_valid |=> sign_flag == $past(result[7])
  ) else $error("sign flag does not follow result msb");

  a_masked_held_off: assert property (
    idle_done && !state_r.mask && !state_r.pend[SRC_TRAP]
    |=> state_r.st != ST_E1
  ) else $error("masked request taken while mask clear");

  a_unmasked_taken: assert property (
    idle_done && no_ret && state_r.mask && (|state_r.pend[2:0])
    |=> state_r.st == ST_E1 && busy
  ) else $error("pending request not recognised with mask set");

  a_mask_set_cause: assert property (
    $rose(global_mask) |->
      $past(exec_mask_set) ||
      ($past(state_r.st == ST_R3) && $past(state_r.is_interrupt_return_instruction))
  ) else $error("mask set without software cause");

  a_mask_clear_late: assert property (
    $fell(global_mask) |->
      $past(state_r.st == ST_E5) || $past(exec_mask_clr)
  ) else $error("mask cleared outside entry end");

  a_push_return_pc: assert property (
    idle_done && no_ret && arb_take
    |=> mem_we && mem_addr == {STACK_PAGE, $past(state_r.sp)}
        && mem_wdata == $past(pc_in[7:0])
  ) else $error("return address not stacked low byte first");

  a_entry_five: assert property (
    $rose(busy) && state_r.st == ST_E1 |-> busy[*5] ##1 !busy && pc_load
  ) else $error("entry does not last five cycles");

  a_interrupt_return_instruction_restores: assert property (
    state_r.st == ST_R3 && state_r.is_interrupt_return_instruction
    |=> global_mask && pc_load
        && stack_ptr == SP_W'($past(state_r.sp) + SP_STEP)
  ) else $error("interrupt return did not restore state");

  a_trap_unmasked: assert property (
    idle_done && no_ret && !state_r.mask && state_r.pend[SRC_TRAP]
    |=> state_r.st == ST_E1 && state_r.vec == VEC_TRAP
  ) else $error("software trap blocked by mask");

  a_trap_clears_mask: assert property (
    state_r.st == ST_E1 && state_r.vec == VEC_TRAP |-> ##5 !global_mask
  ) else $error("software trap left mask set");

  a_wake_first: assert property (
    idle_done && no_ret && state_r.mask && state_r.pend[SRC_WAKE]
    |=> state_r.vec == VEC_WAKE
  ) else $error("wake-up request lost priority");

  a_index_sum: assert property (
    addr_mode == MODE_IDX && !x_ptr[IDX_SPACE_BIT]
    |=> operand_ea == {2'h0, PC_W'($past(x_ptr[9:0]) + $past(op_a))}
  ) else $error("indexed address wrong");

  a_direct_field: assert property (
    addr_mode == MODE_DIR |=> operand_ea == {4'h0, $past(op_a)}
  ) else $error("direct address wrong");

  a_immediate_value: assert property (
    addr_mode == MODE_IMM |=> operand_imm == $past(op_a)
  ) else $error("immediate operand wrong");

  a_inherent_none: assert property (
    addr_mode == MODE_INH |=> operand_bytes == 2'h0
  ) else $error("inherent mode uses operands");

  a_absolute_target: assert property (
    addr_mode == MODE_ABS
    |=> jump_target == {$past(op_a[1:0]), $past(op_b)}
  ) else $error("absolute target wrong");

  a_relative_reach: assert property (
    addr_mode == MODE_REL && op_a[5:0] == 6'h00
    |=> jump_target == PC_W'($past(pc_in) - 10'h01F)
  ) else $error("relative jump reach wrong");

  a_push_by_two: assert property (
    state_r.st == ST_E1 |=> stack_ptr == SP_W'($past(state_r.sp) - SP_STEP)
  ) else $error("push does not lower stack pointer by two");

  a_program_space: assert property (
    addr_mode == MODE_IDX && x_ptr[IDX_SPACE_BIT]
    |=> operand_ea[11:10] == 2'h3
  ) else $error("indexed program space not selected");

  a_pending_holds: assert property (
    state_r.pend[SRC_PWM] && !idle_done |=> state_r.pend[SRC_PWM]
  ) else $error("pending request dropped");

  c_entry_done: cover property (state_r.st == ST_E5 ##1 pc_load);
  c_interrupt_return_instruction_done: cover property (state_r.st == ST_R3 && state_r.is_interrupt_return_instruction);
  c_trap_masked: cover property (
    idle_done && state_r.pend[SRC_TRAP] && !state_r.mask
  );
  c_two_at_once: cover property (
    idle_done && state_r.mask && state_r.pend[SRC_WAKE]
    && state_r.pend[SRC_WDOG]
  );

endmodule // cia_core

`default_nettype wire

// [cia_mem_model.sv]
// Memory partner holding the stack bytes and the vector table
`default_nettype none

module cia_mem_model (
  input wire logic clk,             // Instruction clock
  input wire logic mem_we,          // Byte write
  input wire logic mem_re,          // Byte read
  input wire logic [11:0] mem_addr, // Byte address
  input wire logic [7:0] mem_wdata, // Write data
  output logic [7:0] mem_rdata      // Read data, one cycle late
);
  timeunit 1ns;
  timeprecision 1ps;
  import cia_pkg::*;

  logic [7:0] mem [0:4095];
  logic [11:0] vecs [4];

  // ==========================================================
  // Contents
  initial begin
    vecs = '{VEC_WAKE, VEC_WDOG, VEC_PWM, VEC_TRAP};
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'hA5;
    for (int s = 0; s < 4; s++) begin
      mem[vecs[s]] = 8'(8'h11 * (s + 1));
      mem[vecs[s] + 12'h001] = 8'(s);
    end
    mem_rdata = 8'h00;
  end

  // ==========================================================
  // Access; a bus not being read shows the inverse of its last value
  always @(posedge clk) begin
    if (mem_we) mem[mem_addr] <= mem_wdata;
    mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
  end
endmodule // cia_mem_model

`default_nettype wire

// [cia_core_bench.sv]
// Self-checking bench for the interrupt and addressing core
`default_nettype none

module cia_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cia_pkg::*;

  typedef struct packed {logic [9:0] tgt; logic msk;} cia_note_type;
  logic clk = 1'b0, reset_n = 1'b0, instr_done = 1'b0, exec_trap = 1'b0;
  logic exec_interrupt_return_instruction = 1'b0, exec_ret = 1'b0, exec_mask_set = 1'b0;
  logic exec_mask_clr = 1'b0, sp_load = 1'b0, result_valid = 1'b0;
  logic wake_edge_request = 1'b0, watchdog_timer_request = 1'b0;
  logic pwm_timer_request = 1'b0;
  logic [3:0] sp_wdata = 4'h0, stack_ptr, pending, exp_sp;
  logic [9:0] pc_in = 10'h000, pc_target, jump_target;
  logic [7:0] mem_rdata, result = 8'h00, op_a = 8'h00, op_b = 8'h00;
  logic [7:0] mem_wdata, operand_imm, r;
  logic [10:0] x_ptr = 11'h000;
  logic [11:0] mem_addr, operand_ea;
  logic [1:0] operand_bytes;
  logic busy, mem_we, mem_re, pc_load, global_mask, sign_flag;
  cia_mode_type addr_mode = MODE_INH;
  logic [9:0] stk[$];
  cia_note_type sb[$];
  cia_note_type note;
  int n_errors = 0;
  int n_compared = 0;
  int seed = 32'h5F76;

  always #12.5 clk = ~clk;

  cia_core dut (.clk(clk), .reset_n(reset_n), .instr_done(instr_done),
    .exec_trap(exec_trap), .exec_interrupt_return_instruction(exec_interrupt_return_instruction), .exec_ret(exec_ret),
    .exec_mask_set(exec_mask_set), .exec_mask_clr(exec_mask_clr),
    .sp_load(sp_load), .sp_wdata(sp_wdata), .pc_in(pc_in),
    .wake_edge_request(wake_edge_request),
    .watchdog_timer_request(watchdog_timer_request),
    .pwm_timer_request(pwm_timer_request), .mem_rdata(mem_rdata),
    .result_valid(result_valid), .result(result), .addr_mode(addr_mode),
    .x_ptr(x_ptr), .op_a(op_a), .op_b(op_b), .busy(busy), .mem_we(mem_we),
    .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .pc_load(pc_load), .pc_target(pc_target), .stack_ptr(stack_ptr),
    .global_mask(global_mask), .sign_flag(sign_flag), .pending(pending),
    .operand_ea(operand_ea), .operand_imm(operand_imm),
    .jump_target(jump_target), .operand_bytes(operand_bytes));

  cia_mem_model mdl (.clk(clk), .mem_we(mem_we), .mem_re(mem_re),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // ==========================================================
  // Compare and report
  task automatic cmp_val(input logic [11:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, exp, input string what);
    cmp_val({11'h000, got}, {11'h000, exp}, what);
  endtask

  task automatic wrap_up();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Vector contents held by the memory partner
  function automatic logic [9:0] vtgt(input int s);
    return {2'(s), 8'(8'h11 * (s + 1))};
  endfunction

  // ==========================================================
  // Sequence tasks
  task automatic wait_load(input logic m, output int nb);
    nb = 0;
    for (int i = 0; i < 20; i++) begin
      if (pc_load === 1'b1) return;
      if (busy === 1'b1) nb++;
      cmp_flag(global_mask, m, "mask in sequence");
      @(negedge clk);
    end
    n_errors++;
    wrap_up();
  endtask

  task automatic entry(input logic [9:0] pc, input int s);
    int nb;
    sb.push_back('{vtgt(s), 1'b0});
    stk.push_back(pc);
    pc_in = pc;
    instr_done = 1'b1;
    @(negedge clk);
    instr_done = 1'b0;
    wait_load(global_mask, nb);
    cmp_val(12'(nb), 12'h005, "entry length");
    cmp_val({4'h0, mdl.mem[{8'h03, exp_sp}]}, {4'h0, pc[7:0]}, "pc lo");
    cmp_val({4'h0, mdl.mem[{8'h03, exp_sp - 4'h1}]}, {10'h000, pc[9:8]},
      "pc hi");
    exp_sp = exp_sp - 4'h2;
    cmp_val({8'h00, stack_ptr}, {8'h00, exp_sp}, "sp after push");
  endtask

  task automatic leave(input logic is_interrupt_return_instruction);
    int nb;
    sb.push_back('{stk.pop_back(), is_interrupt_return_instruction ? 1'b1 : global_mask});
    exec_interrupt_return_instruction = is_interrupt_return_instruction;
    exec_ret = ~is_interrupt_return_instruction;
    @(negedge clk);
    exec_interrupt_return_instruction = 1'b0;
    exec_ret = 1'b0;
    wait_load(global_mask, nb);
    exp_sp = exp_sp + 4'h2;
    cmp_val({8'h00, stack_ptr}, {8'h00, exp_sp}, "sp after pull");
  endtask

  // ==========================================================
  // Result monitor
  always @(negedge clk) begin
    if (reset_n === 1'b1 && pc_load === 1'b1) begin
      if (sb.size() == 0) cmp_flag(1'b0, 1'b1, "unexpected load");
      else begin
        note = sb.pop_front();
        cmp_val({2'b00, pc_target}, {2'b00, note.tgt}, "target");
        cmp_flag(global_mask, note.msk, "mask after load");
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    cmp_flag(global_mask, 1'b0, "mask at reset");
    cmp_val({8'h00, stack_ptr}, 12'h00F, "sp at reset");
    sp_load = 1'b1;
    sp_wdata = 4'hB;
    @(negedge clk);
    sp_load = 1'b0;
    exp_sp = 4'hB;
    cmp_val({8'h00, stack_ptr}, 12'h00B, "sp load");
    result_valid = 1'b1;
    for (int i = 0; i < 10; i++) begin
      r = (i < 2) ? 8'h7F + 8'(i) : 8'($random(seed));
      result = r;
      @(negedge clk);
      cmp_flag(sign_flag, r[7], "sign");
    end
    result_valid = 1'b0;
    for (int i = 0; i < 30; i++) begin
      addr_mode = cia_mode_type'(i % 6);
      x_ptr = 11'($random(seed));
      op_a = (i == 5) ? 8'hC0 : 8'($random(seed));
      op_b = 8'($random(seed));
      pc_in = 10'($random(seed));
      @(negedge clk);
      case (addr_mode)
        MODE_IDX: cmp_val(operand_ea, (x_ptr[10] ? 12'hC00 : 12'h000) |
          {2'b00, x_ptr[9:0] + {2'b00, op_a}}, "indexed");
        MODE_DIR: cmp_val(operand_ea, {4'h0, op_a}, "direct");
        MODE_IMM: cmp_val({4'h0, operand_imm}, {4'h0, op_a}, "imm");
        MODE_INH: cmp_val({10'h000, operand_bytes}, 12'h000, "inh");
        MODE_ABS: cmp_val({2'b00, jump_target}, {2'b00, op_a[1:0], op_b},
          "absolute");
        default: cmp_val({2'b00, jump_target},
          {2'b00, pc_in + {4'h0, op_a[5:0]} - 10'h01F}, "relative");
      endcase
    end
    wake_edge_request = 1'b1;
    instr_done = 1'b1;
    @(negedge clk);
    wake_edge_request = 1'b0;
    repeat (3) @(negedge clk);
    instr_done = 1'b0;
    cmp_flag(busy, 1'b0, "masked taken");
    cmp_val({8'h00, pending}, 12'h001, "held pending");
    exec_mask_set = 1'b1;
    watchdog_timer_request = 1'b1;
    pwm_timer_request = 1'b1;
    exec_trap = 1'b1;
    @(negedge clk);
    exec_mask_set = 1'b0;
    watchdog_timer_request = 1'b0;
    pwm_timer_request = 1'b0;
    exec_trap = 1'b0;
    cmp_flag(global_mask, 1'b1, "mask set");
    cmp_val({8'h00, pending}, 12'h00F, "all pending");
    entry(10'h123, SRC_WAKE);
    entry(10'h2A5, SRC_TRAP);
    leave(1'b0);
    leave(1'b1);
    entry(10'h3FF, SRC_WDOG);
    leave(1'b1);
    entry(10'h000, SRC_PWM);
    leave(1'b1);
    exec_trap = 1'b1;
    @(negedge clk);
    exec_trap = 1'b0;
    entry(10'h155, SRC_TRAP);
    leave(1'b1);
    exec_mask_clr = 1'b1;
    @(negedge clk);
    exec_mask_clr = 1'b0;
    cmp_flag(global_mask, 1'b0, "mask clear");
    cmp_val({8'h00, pending}, 12'h000, "all served");
    wrap_up();
  end
endmodule // cia_core_bench

`default_nettype wire
